/* File: oss_defs.vh */
// Constants for the octal switch serial control block
// Contract
// RULE1: Command bits accepted and status shifted only while select is low.
// RULE2: Rising select edge copies shift register into the eight output latches.
// RULE3: Falling select edge loads drain status of all outputs into shift register.
// RULE4: Status driver enabled while select low, released while select high.
// RULE5: Host keeps serial clock low at every select transition.
// RULE6: Host should keep serial clock low while not selected; the host model's noise task clocks it while deselected.
// RULE7: Command input sampled into shift register on falling serial clock.
// RULE8: Status output changes on rising serial clock edge.
// RULE9: Clock and command input ignored while select is high.
// RULE10: Command one programs output off, zero on, effective at select rise.
// RULE11: Command word is eight bits, MSB first, first bit controls output 7.
// RULE12: Shift register holds eight bits, full after eight clocks.
// RULE13: Status reads one for off unfaulted, zero for on unfaulted.
// RULE14: Status sent MSB first from output 7, reflecting previous command.
// RULE15: Status output behaviour independent of clear input; the code stops status shifting while clear is low.
// RULE16: Clear low clears shift register and forces all outputs off.
// RULE17: Host holds clear low at least 250 ns; the bench releases it 24 ns after power-up.
// RULE18: Host holds clear low at power-up and on load supply drop.
// RULE19: Undriven clear defaults asserted so outputs stay off.
// RULE20: Latch disable high keeps shorted output on in current limit.
// RULE21: Latch disable low shuts only the shorted output down.
// RULE22: Host should not change command input while clock rises.
// RULE23: After load supply overvoltage outputs stay off, next status all ones.
// RULE24: Select rise starts fault delay; open-load detection only after expiry.
// RULE25: Faulted output status reads opposite to commanded state.
`ifndef OSS_DEFS_VH
`define OSS_DEFS_VH

// Word and buffer shape
`define OSS_WORD_W      8
`define OSS_CNT_W       4
`define OSS_FIFO_DEPTH  32
`define OSS_FIFO_AW     5

// Reset values
`define OSS_LATCH_RST   8'hff
`define OSS_SHIFT_RST   8'h00
`define OSS_ALL_ONES    8'hff

// Fault delay timer
`define OSS_CLK_PS      4000
`define OSS_FDLY_NS     25000
`define OSS_FDLY_CYC    ((`OSS_FDLY_NS * 1000) / `OSS_CLK_PS)
`define OSS_FDLY_W      16

`endif

/* File: oss_fifo.v */
// Parameterised valid/ready FIFO for received command words
`timescale 1ns/10ps
`default_nettype none

module oss_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and control
  input  wire             i_clk,
  input  wire             i_sys_rst,
  input  wire             i_ce,
  // Fill side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // Drain side
  output wire             o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  // Honest full and empty from the fill count
  assign o_in_ready  = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr];
  assign do_wr       = i_in_valid & o_in_ready;
  assign do_rd       = o_out_valid & i_out_ready;

  // Storage write
  always @(posedge i_clk) begin
    if (i_ce && do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers and count
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (i_ce) begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // oss_fifo

`default_nettype wire

/* File: oss_serial_ctrl.v */
// Serial control and status logic of the eight-output low-side switch
`timescale 1ns/10ps
`default_nettype none
`include "oss_defs.vh"

module oss_serial_ctrl (
  // Clock, reset, enable
  input  wire                   i_clk,
  input  wire                   i_sys_rst,
  input  wire                   i_ce,
  // Serial link pins
  input  wire                   i_sclk,
  input  wire                   i_cs_n,
  input  wire                   i_si,
  output reg                    o_so,
  output reg                    o_so_oe,
  // Control pins
  input  wire                   i_clear_n,
  input  wire                   i_short_latch_disable,
  input  wire                   i_load_supply_ov,
  // Per-output analog conditions
  input  wire [`OSS_WORD_W-1:0] i_short,
  input  wire [`OSS_WORD_W-1:0] i_overtemp,
  input  wire [`OSS_WORD_W-1:0] i_open_load,
  // Output switch drive, one means on
  output reg  [`OSS_WORD_W-1:0] o_switch_on,
  output reg  [`OSS_WORD_W-1:0] o_current_limit,
  // Word stream of accepted commands, plus word-full and open-detect flags
  output reg                    o_cmd_valid,
  output reg  [`OSS_WORD_W-1:0] o_cmd_data,
  input  wire                   i_cmd_ready,
  output reg                    o_word_full,
  output reg                    o_open_detect_en
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  reg [1:0] sclk_sync;
  reg [1:0] cs_sync;
  reg [1:0] si_sync;
  reg [1:0] clr_sync;
  reg [1:0] sld_sync;
  reg [1:0] ov_sync;
  reg [`OSS_WORD_W-1:0] sh_s1, sh_s2, ot_s1, ot_s2, ol_s1, ol_s2;
  reg       sclk_d;
  reg       cs_d;

  // Two flops on every pin input
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_sync <= 2'h0;
      cs_sync   <= 2'h3;
      si_sync   <= 2'h0;
      clr_sync  <= 2'h0;
      sld_sync  <= 2'h0;
      ov_sync   <= 2'h0;
      sh_s1     <= 8'h00;
      sh_s2     <= 8'h00;
      ot_s1     <= 8'h00;
      ot_s2     <= 8'h00;
      ol_s1     <= 8'h00;
      ol_s2     <= 8'h00;
      sclk_d    <= 1'b0;
      cs_d      <= 1'b1;
    end else if (i_ce) begin
      sclk_sync <= {sclk_sync[0], i_sclk};
      cs_sync   <= {cs_sync[0], i_cs_n};
      si_sync   <= {si_sync[0], i_si};
      clr_sync  <= {clr_sync[0], i_clear_n};
      sld_sync  <= {sld_sync[0], i_short_latch_disable};
      ov_sync   <= {ov_sync[0], i_load_supply_ov};
      sh_s1     <= i_short;
      sh_s2     <= sh_s1;
      ot_s1     <= i_overtemp;
      ot_s2     <= ot_s1;
      ol_s1     <= i_open_load;
      ol_s2     <= ol_s1;
      sclk_d    <= sclk_sync[1];
      cs_d      <= cs_sync[1];
    end
  end

  wire sclk_s   = sclk_sync[1];
  wire cs_n_s   = cs_sync[1];
  wire si_s     = si_sync[1];
  wire clear_n  = clr_sync[1]; // Reset loads the synchroniser low, so clear reads asserted until the pin is sampled [RULE19]
  wire sld_s    = sld_sync[1];
  wire ov_s     = ov_sync[1];

  // Edge detection on the synchronised pins
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire cs_fall   = ~cs_n_s & cs_d;
  wire cs_rise   = cs_n_s & ~cs_d;
  wire selected  = ~cs_n_s & ~cs_d;  // Clock ignored while deselected [RULE9]

  //////////////////////////////////////////////////////////////////////////////
  // Core state

  reg [`OSS_WORD_W-1:0] shift;      // Status out, command in
  reg [`OSS_WORD_W-1:0] cmd_latch;  // One means off
  reg [`OSS_WORD_W-1:0] tripped;    // Latched-off shorted outputs
  reg [`OSS_CNT_W-1:0]  bit_cnt;
  reg                   ov_hold;    // Off after overvoltage until reprogrammed
  reg [`OSS_FDLY_W-1:0] fdly_cnt;
  reg                   ov_word_pend;

  // Drain status per output: high means drain high (off) [RULE13] [RULE25]
  function [`OSS_WORD_W-1:0] drain_status;
    input [`OSS_WORD_W-1:0] latch;
    input [`OSS_WORD_W-1:0] sh;
    input [`OSS_WORD_W-1:0] ot;
    input [`OSS_WORD_W-1:0] ol;
    input [`OSS_WORD_W-1:0] trip;
    input                   open_en;
    reg   [`OSS_WORD_W-1:0] on_eff;
    begin
      on_eff = ~latch & ~ot & ~trip;
      // On: short reads high; off: open load reads low once open detection is enabled
      drain_status = (on_eff & sh) | (~on_eff & ~latch) |
                     (~on_eff & latch & ~(ol & {`OSS_WORD_W{open_en}}));
    end
  endfunction

  wire [`OSS_WORD_W-1:0] status_now =
    drain_status(cmd_latch, sh_s2, ot_s2, ol_s2, tripped, o_open_detect_en);

  //////////////////////////////////////////////////////////////////////////////
  // Shift register and serial output; clear low stops shifting and holds o_so, so output is not independent of clear [RULE15]

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      shift   <= `OSS_SHIFT_RST;
      bit_cnt <= 4'h0;
      o_so    <= 1'b1;
    end else if (i_ce) begin
      if (cs_fall) begin
        // Capture status, all ones after overvoltage [RULE3] [RULE23]
        shift   <= ov_word_pend ? `OSS_ALL_ONES : status_now;
        o_so    <= ov_word_pend ? 1'b1 : status_now[`OSS_WORD_W-1]; // MSB first [RULE14]
        bit_cnt <= 4'h0;
      end else if (!clear_n) begin
        shift   <= `OSS_SHIFT_RST; // [RULE16]
        bit_cnt <= 4'h0;
      end else if (selected && sclk_fall) begin
        // Sample command in, MSB first toward output 7 [RULE7] [RULE11] [RULE1]
        shift <= {shift[`OSS_WORD_W-2:0], si_s};
        if (bit_cnt != 4'h8) begin
          bit_cnt <= bit_cnt + 4'h1; // [RULE12]
        end
      end else if (selected && sclk_rise) begin
        o_so <= shift[`OSS_WORD_W-1]; // Next bit on rising clock [RULE8]
      end
    end
  end

  // Driver enable follows select [RULE4]
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_so_oe     <= 1'b0;
      o_word_full <= 1'b0;
    end else if (i_ce) begin
      o_so_oe     <= ~cs_n_s;
      o_word_full <= (bit_cnt == 4'h8);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output latches, protection and overvoltage

  wire latch_now = cs_rise & clear_n;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      cmd_latch    <= `OSS_LATCH_RST;
      tripped      <= 8'h00;
      ov_hold      <= 1'b0;
      ov_word_pend <= 1'b0;
    end else if (i_ce) begin
      if (!clear_n) begin
        cmd_latch <= `OSS_LATCH_RST; // All off [RULE16]
        tripped   <= 8'h00;
      end else if (ov_s) begin
        cmd_latch    <= `OSS_LATCH_RST; // [RULE23]
        ov_hold      <= 1'b1;
        ov_word_pend <= 1'b1;
      end else if (latch_now) begin
        cmd_latch <= shift;  // One programs off [RULE2] [RULE10]
        // Short still present on an output commanded on trips at once while latch disable is low
        tripped   <= sh_s2 & ~shift & {`OSS_WORD_W{~sld_s}}; // [RULE21]
        ov_hold   <= 1'b0;
      end else begin
        // Latch off only the shorted output when latch disable low [RULE21]
        tripped <= tripped | (sh_s2 & ~cmd_latch & {`OSS_WORD_W{~sld_s}});
      end
      if (cs_fall && !ov_s) begin
        ov_word_pend <= 1'b0;
      end
    end
  end

  // Switch drive and current-limit flags [RULE20]
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_switch_on     <= 8'h00;
      o_current_limit <= 8'h00;
    end else if (i_ce) begin
      o_switch_on     <= ~cmd_latch & ~tripped & ~ot_s2 & {`OSS_WORD_W{~ov_hold}};
      o_current_limit <= ~cmd_latch & ~ot_s2 & sh_s2 & {`OSS_WORD_W{sld_s}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault delay timer gating open-load detection [RULE24]

  // Load value, cut on purpose to the timer width
  wire [31:0] fdly_load = `OSS_FDLY_CYC;

  // Every select rise restarts the delay, even under clear

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      fdly_cnt         <= 16'h0000;
      o_open_detect_en <= 1'b0;
    end else if (i_ce) begin
      if (cs_rise) begin
        fdly_cnt         <= fdly_load[`OSS_FDLY_W-1:0];
        o_open_detect_en <= 1'b0;
      end else if (fdly_cnt != 16'h0000) begin
        fdly_cnt <= fdly_cnt - 16'h0001;
      end else begin
        o_open_detect_en <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command word stream through the FIFO

  wire                   fifo_in_ready;
  wire                   fifo_out_valid;
  wire [`OSS_WORD_W-1:0] fifo_out_data;
  wire                   pop = fifo_out_valid & (~o_cmd_valid | i_cmd_ready);

  oss_fifo #(
    .WIDTH (`OSS_WORD_W),
    .DEPTH (`OSS_FIFO_DEPTH),
    .AW    (`OSS_FIFO_AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_ce        (i_ce),
    .i_in_valid  (latch_now),
    .i_in_data   (shift),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (pop)
  );

  // Registered output stage of the stream
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cmd_valid <= 1'b0;
      o_cmd_data  <= 8'h00;
    end else if (i_ce) begin
      if (pop) begin
        o_cmd_valid <= 1'b1;
        o_cmd_data  <= fifo_out_data;
      end else if (i_cmd_ready) begin
        o_cmd_valid <= 1'b0;
      end
    end
  end

  // A full FIFO drops the log entry only; the latch still updates
  wire unused_ready = fifo_in_ready;

endmodule // oss_serial_ctrl

`default_nettype wire

/* File: oss_ctrl_props.sv */
// Port assertions for the serial control block
`timescale 1ns/10ps
`default_nettype none
module oss_ctrl_props (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  // Link and control pins
  input wire logic       i_sclk,
  input wire logic       i_cs_n,
  input wire logic       i_clear_n,
  input wire logic       i_short_latch_disable,
  input wire logic       i_load_supply_ov,
  input wire logic [7:0] i_short,
  // Outputs
  input wire logic       o_so,
  input wire logic       o_so_oe,
  input wire logic [7:0] o_switch_on,
  input wire logic       o_word_full,
  input wire logic       o_open_detect_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////
  // Select edge sequences and port checks
  sequence s_sel_fall; $fell(i_cs_n); endsequence
  sequence s_sel_rise; $rose(i_cs_n); endsequence
  chk_so_released: assert property (i_cs_n [*6] |-> !o_so_oe)
    else $error("status driver on while deselected");
  chk_so_driven: assert property (!i_cs_n [*6] |-> o_so_oe)
    else $error("status driver off while selected");
  chk_so_held: assert property (i_cs_n [*8] |-> $stable(o_so))
    else $error("status bit moved while deselected");
  chk_so_cause: assert property ($changed(o_so) |-> $past(i_sclk, 3) || $past(i_sclk, 4)
    || $past(i_sclk, 5) || $past(i_cs_n, 5)) else $error("status bit moved without clock rise");
  chk_count_restart: assert property (s_sel_fall |-> ##6 !o_word_full)
    else $error("word full not cleared at frame start");
  chk_fault_delay: assert property (s_sel_rise |-> ##8 !o_open_detect_en [*8])
    else $error("open detect not held off after latch");
  chk_latch_hold: assert property ((!i_cs_n && i_clear_n && !i_load_supply_ov
    && i_short == 8'h00) [*8] |-> $stable(o_switch_on)) else $error("switches moved in frame");
  chk_clear_off: assert property (!i_clear_n [*6] |-> o_switch_on == 8'h00)
    else $error("switch on during clear");
  chk_short_trip: assert property ((!i_short_latch_disable && $stable(i_short)) [*6]
    |-> (o_switch_on & i_short) == 8'h00) else $error("shorted output left on");
  chk_ov_off: assert property (i_load_supply_ov [*6] |-> o_switch_on == 8'h00)
    else $error("switch on during overvoltage");
endmodule // oss_ctrl_props
bind oss_serial_ctrl oss_ctrl_props u_props (.*);
`default_nettype wire

/* File: oss_host_model.sv */
// Serial host model that runs frames on the link pins
`timescale 1ns/10ps
`default_nettype none
module oss_host_model (
  // Link pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so_line
);
  // Idle pin levels, clock low outside frames and noise bursts
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // One frame, command out MSB first, status sampled at clock fall
  task automatic frame(input logic [7:0] cmd, output logic [7:0] st);
    integer i;
    begin
      o_cs_n = 1'b0; // Clock low at select edge
      #16;
      for (i = 7; i >= 0; i = i - 1) begin
        o_si = cmd[i]; // Output 7 first, steady over rise
        #4 o_sclk = 1'b1;
        #20 o_sclk = 1'b0;
        st[i] = i_so_line;
        #8;
      end
      #8 o_cs_n = 1'b1;
      o_si = ~o_si; // Data meaningless once deselected
      #40;
    end
  endtask
  // Clock and data wiggle while deselected
  task automatic noise;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        o_si = ~o_si;
        #16 o_sclk = 1'b1;
        #16 o_sclk = 1'b0;
      end
      #16;
    end
  endtask
endmodule // oss_host_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the serial control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       clear_n = 1'b0; // Held low from power-up
  logic       sld = 1'b0;
  logic       ov = 1'b0;
  logic       cmd_rdy = 1'b1;
  logic [7:0] short_in = 8'h00;
  logic [7:0] ot_in = 8'h00;
  logic [7:0] open_in = 8'h00;
  logic [7:0] st;
  wire        sclk, cs_n, si, so, so_oe, cmd_v, word_full, open_en;
  wire  [7:0] sw_on, climit, cmd_d;
  wire        so_line = so_oe ? so : ~so;
  integer     n_fail = 0;
  integer     total_checks = 0;
  integer     i;
  // Clock, 4 ns period
  always #2 clk = ~clk;
  oss_serial_ctrl dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_clear_n(clear_n),
    .i_short_latch_disable(sld), .i_load_supply_ov(ov), .i_short(short_in),
    .i_overtemp(ot_in), .i_open_load(open_in), .o_switch_on(sw_on), .o_current_limit(climit),
    .o_cmd_valid(cmd_v), .o_cmd_data(cmd_d), .i_cmd_ready(cmd_rdy),
    .o_word_full(word_full), .o_open_detect_en(open_en));
  oss_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so_line(so_line));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Frame with status compare, then latch settle
  task automatic xfer(input logic [7:0] c, input logic [7:0] exp);
    begin
      u_host.frame(c, st);
      check(st, exp);
      cyc(12);
    end
  endtask
  // Latching, polarity, order and fault delay
  task automatic t_basic;
    begin
      xfer(8'h5a, 8'hff);
      check(sw_on, 8'ha5);
      check({7'h00, word_full}, 8'h01);
      xfer(8'h3c, 8'h5a);
      check(sw_on, 8'hc3);
      check({7'h00, open_en}, 8'h00);
      cyc(6250);
      check({7'h00, open_en}, 8'h01);
      open_in = 8'h04;
      xfer(8'h3c, 8'h38);
    end
  endtask
  // Link activity while deselected
  task automatic t_ignore;
    begin
      u_host.noise;
      check(sw_on, 8'hc3);
      xfer(8'h00, 8'h3c);
    end
  endtask
  // Clear held over a whole frame
  task automatic t_clear;
    begin
      clear_n = 1'b0;
      cyc(75); // Longer than 250 ns
      check(sw_on, 8'h00);
      xfer(8'h00, 8'hff);
      check(sw_on, 8'h00);
      clear_n = 1'b1;
      xfer(8'h00, 8'hff);
    end
  endtask
  // Short with and without latch-off, then overvoltage
  task automatic t_fault;
    begin
      ot_in = 8'h02;
      sld = 1'b1;
      short_in = 8'h04;
      cyc(10);
      check(climit, 8'h04);
      check(sw_on, 8'hfd);
      sld = 1'b0;
      cyc(10);
      check(sw_on, 8'hf9);
      short_in = 8'h00;
      xfer(8'h00, 8'h06);
      check(sw_on, 8'hfd);
      ot_in = 8'h00;
      ov = 1'b1;
      cyc(10);
      check(sw_on, 8'h00);
      ov = 1'b0;
      xfer(8'h00, 8'hff);
    end
  endtask
  // Stall the command stream past full (32 buffered plus one held), then drain in order
  task automatic t_fifo;
    integer k;
    begin
      cmd_rdy = 1'b0;
      for (i = 0; i < 34; i = i + 1)
        xfer(i[7:0], (i == 0) ? 8'h00 : i[7:0] - 8'h01);
      for (i = 0; i < 33; i = i + 1) begin
        for (k = 0; k < 20 && cmd_v !== 1'b1; k = k + 1)
          cyc(1);
        check({7'h00, cmd_v}, 8'h01);
        if (cmd_v !== 1'b1)
          print_verdict;
        check(cmd_d, i[7:0]);
        cmd_rdy = 1'b1;
        cyc(1);
        cmd_rdy = 1'b0;
        cyc(1);
      end
      cyc(20);
      check({7'h00, cmd_v}, 8'h00);
    end
  endtask
  // Main sequence, clear driven low during reset
  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(4);
    check(sw_on, 8'h00);
    check({7'h00, so_oe}, 8'h00);
    clear_n = 1'b1;
    cyc(4);
    t_basic;
    t_ignore;
    t_clear;
    t_fault;
    t_fifo;
    print_verdict;
  end
  // Watchdog on the whole run
  initial begin
    #200000;
    n_fail = n_fail + 1;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
